/* jsf_map.svh */
// Register offsets, field positions, reset values and coding constants for the framer
`ifndef JSF_MAP_SVH
`define JSF_MAP_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define JSF_OFF_CTRL     8'h00
`define JSF_OFF_STAT     8'h04
`define JSF_OFF_PAR      8'h08

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define JSF_EN_BIT       0
`define JSF_MODE_LO      1
`define JSF_E_LO         8
`define JSF_BIDX_LO      0
`define JSF_MIDX_LO      8
`define JSF_REAL_BIT     16

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define JSF_EN_RST       1'b0
`define JSF_E_RST        8'h01

// ----------------------------------------------------------------
// Coding constants
// ----------------------------------------------------------------
`define JSF_MB_LAST      5'h1F
// Feedback taps below the top term: x^12 is implicit, leaving x^9+x^8+x^3+x^2+x+1
`define JSF_CRC_POLY     26'h000030F
`define JSF_FEC_POLY     26'h0220211
`define JSF_CRC_TOP      11
`define JSF_FEC_TOP      25

`endif

/* jsf_pkg.sv */
// Types shared by the framer modules
package jsf_pkg;
  typedef enum logic [1:0] {
    JSF_MODE_CRC12 = 2'h0,
    JSF_MODE_FEC   = 2'h2
  } jsf_mode_e;
  typedef logic [65:0] jsf_blk_t;
endpackage : jsf_pkg

/* jsf_par_if.sv */
// Carrier between the framer and its parity engine
`timescale 1ns/10ps
`default_nettype none
interface jsf_par_if;
  logic        clr;
  logic        vld;
  logic [63:0] dat;
  logic [11:0] crc;
  logic [25:0] fec;
  modport src (output clr, output vld, output dat, input crc, input fec);
  modport eng (input clr, input vld, input dat, output crc, output fec);
endinterface : jsf_par_if
`default_nettype wire

/* jsf_parity.sv */
// CRC-12 and FEC parity engine, 64 payload bits per block
`timescale 1ns/10ps
`default_nettype none
`include "jsf_map.svh"
module jsf_parity (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  jsf_par_if.eng   pif
);
  import jsf_pkg::*;

  // Serial LFSR step over one block, first transmitted bit first
  function automatic logic [25:0] par_step(input logic [25:0] s, input logic [63:0] d,
                                           input logic [25:0] poly, input int top);
    logic [25:0] st;
    logic        fb;
    st = s;
    for (int i = 0; i < 64; i++) begin
      fb = d[i] ^ st[top];
      st = st << 1;
      if (fb) begin
        st = st ^ poly;
      end
    end
    return st;
  endfunction : par_step

  // ----------------------------------------------------------------
  // Parity state
  // ----------------------------------------------------------------
  logic [25:0] crc_seed;
  logic [25:0] fec_seed;
  logic [25:0] next_crc;
  logic [25:0] next_fec;
  logic [25:0] crc_fresh;
  logic [25:0] fec_fresh;

  // Stages restart from zero on the first block of a multiblock
  assign crc_seed = pif.clr ? 26'h0000000 : {14'h0000, pif.crc};
  assign fec_seed = pif.clr ? 26'h0000000 : pif.fec;
  assign next_crc = par_step(crc_seed, pif.dat, `JSF_CRC_POLY, `JSF_CRC_TOP);
  assign next_fec = par_step(fec_seed, pif.dat, `JSF_FEC_POLY, `JSF_FEC_TOP);
  // One block from cleared stages, so the check below sees stale state leak in
  assign crc_fresh = par_step(26'h0000000, pif.dat, `JSF_CRC_POLY, `JSF_CRC_TOP);
  assign fec_fresh = par_step(26'h0000000, pif.dat, `JSF_FEC_POLY, `JSF_FEC_TOP);

  // Shift in each accepted block
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      pif.crc <= 12'h000;
      pif.fec <= 26'h0000000;
    end else if (pif.vld) begin
      pif.crc <= next_crc[11:0];
      pif.fec <= next_fec;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  crc_clear_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (pif.vld && pif.clr) |=> (pif.crc == $past(crc_fresh[11:0]) && pif.fec == $past(fec_fresh)))
    else $error("parity not cleared at multiblock start");
endmodule : jsf_parity
`default_nettype wire

/* jsf_framer.sv */
// 64b/66b sync header framer: multiblocks, extended multiblocks, LEMC and CRC-12/FEC stream
//
// Implementation choices: the APB register port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "jsf_map.svh"
module jsf_framer (
  input  wire logic            sys_clk_in,
  input  wire logic            rst_in,
  input  wire logic            psel_in,
  input  wire logic            penable_in,
  input  wire logic            pwrite_in,
  input  wire logic [7:0]      paddr_in,
  input  wire logic [31:0]     pwdata_in,
  output var  logic [31:0]     prdata_out,
  output var  logic            pready_out,
  output var  logic            pslverr_out,
  input  wire logic            sysref_in,
  input  wire logic            blk_vld_in,
  input  wire logic [63:0]     blk_data_in,
  output var  logic            blk_vld_out,
  output var  jsf_pkg::jsf_blk_t blk_out,
  output var  logic            lemc_out
);
  import jsf_pkg::*;

  // Self-synchronous scrambler 1 + x^39 + x^58, first transmitted bit first
  function automatic logic [121:0] scramble(input logic [57:0] s, input logic [63:0] d);
    logic [57:0] st;
    logic [63:0] o;
    st = s;
    o  = 64'h0;
    for (int i = 0; i < 64; i++) begin
      o[i] = d[i] ^ st[38] ^ st[57];
      st   = {st[56:0], o[i]};
    end
    return {st, o};
  endfunction : scramble

  // FEC stream layout: parity reversed into 0..21 and 23..26, flag at 22, pilot on top
  function automatic logic [31:0] fec_layout(input logic [25:0] p, input logic e);
    logic [31:0] w;
    w = 32'h8000_0000;
    for (int i = 0; i < 22; i++) begin
      w[i] = p[25 - i];
    end
    for (int i = 0; i < 4; i++) begin
      w[23 + i] = p[3 - i];
    end
    w[22] = e;
    return w;
  endfunction : fec_layout

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  logic        en;
  jsf_mode_e   mode;
  logic [7:0]  e_len;
  logic        setup;
  logic        wr_acc;
  logic        hit;
  logic [31:0] rd_word;
  logic [7:0]  e_m1;
  logic [1:0]  wr_mode;

  assign setup   = psel_in & ~penable_in;
  assign wr_acc  = psel_in & penable_in & pready_out & pwrite_in;
  assign hit     = (paddr_in == `JSF_OFF_CTRL) | (paddr_in == `JSF_OFF_STAT) |
                   (paddr_in == `JSF_OFF_PAR);
  assign wr_mode = pwdata_in[`JSF_MODE_LO +: 2];
  // A zero length is treated as one multiblock per extended multiblock
  assign e_m1    = (e_len == 8'h00) ? 8'h00 : e_len - 8'h01;

  // Control writes; unsupported sync header modes are ignored
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      en    <= `JSF_EN_RST;
      mode  <= JSF_MODE_CRC12;
      e_len <= `JSF_E_RST;
    end else if (wr_acc && paddr_in == `JSF_OFF_CTRL) begin
      en    <= pwdata_in[`JSF_EN_BIT];
      e_len <= pwdata_in[`JSF_E_LO +: 8];
      if (wr_mode == JSF_MODE_CRC12 || wr_mode == JSF_MODE_FEC) begin
        mode <= jsf_mode_e'(wr_mode);
      end
    end
  end

  // ----------------------------------------------------------------
  // APB slave: no wait states, answer registered in the setup cycle
  // ----------------------------------------------------------------
  logic [4:0]  blk_idx;
  logic [7:0]  mb_idx;
  logic        realign;
  logic [11:0] crc_hold;
  logic [25:0] fec_hold;

  assign rd_word =
    (paddr_in == `JSF_OFF_CTRL) ? {16'h0000, e_len, 5'h00, mode, en} :
    (paddr_in == `JSF_OFF_STAT) ? {15'h0000, realign, mb_idx, 3'h0, blk_idx} :
    (paddr_in == `JSF_OFF_PAR)  ? ((mode == JSF_MODE_FEC) ? {6'h00, fec_hold} :
                                                           {20'h00000, crc_hold}) :
    32'h0000_0000;

  // Ready and read data come up in the cycle after setup
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out  <= 32'h0000_0000;
    end else begin
      pready_out  <= setup;
      pslverr_out <= setup & ~hit;
      if (setup) begin
        prdata_out <= rd_word;
      end
    end
  end

  // ----------------------------------------------------------------
  // SYSREF capture and realignment
  // ----------------------------------------------------------------
  logic sr_q1;
  logic sr_q2;
  logic sr_q3;
  logic sr_edge;
  logic blk_take;

  assign sr_edge  = sr_q2 & ~sr_q3;
  assign blk_take = blk_vld_in & en;

  // Two-stage synchroniser, then edge detect on the settled stages
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      sr_q1   <= 1'b0;
      sr_q2   <= 1'b0;
      sr_q3   <= 1'b0;
      realign <= 1'b0;
    end else begin
      sr_q1   <= sysref_in;
      sr_q2   <= sr_q1;
      sr_q3   <= sr_q2;
      realign <= sr_edge | (realign & ~blk_take);
    end
  end

  // ----------------------------------------------------------------
  // Block and multiblock counting
  // ----------------------------------------------------------------
  logic [4:0] eff_blk;
  logic [7:0] eff_mb;
  logic       mb_last;
  logic       blk_end;

  // A pending realignment restarts the next block at LEMC phase zero
  assign eff_blk = realign ? 5'h00 : blk_idx;
  assign eff_mb  = realign ? 8'h00 : mb_idx;
  assign mb_last = (eff_mb >= e_m1);
  assign blk_end = (eff_blk == `JSF_MB_LAST);

  // Counters advance per accepted block; LEMC pulses on the last block of an extended multiblock
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      blk_idx  <= 5'h00;
      mb_idx   <= 8'h00;
      lemc_out <= 1'b0;
    end else begin
      lemc_out <= blk_take & blk_end & mb_last;
      if (sr_edge) begin
        blk_idx <= 5'h00;
        mb_idx  <= 8'h00;
      end else if (blk_take) begin
        blk_idx <= eff_blk + 5'h01;
        if (blk_end) begin
          mb_idx <= mb_last ? 8'h00 : eff_mb + 8'h01;
        end else begin
          mb_idx <= eff_mb;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Scrambler and parity engine
  // ----------------------------------------------------------------
  logic [57:0]  scr_st;
  logic [121:0] scr_res;
  logic [63:0]  scr_data;
  jsf_par_if    pif ();

  assign scr_res  = scramble(scr_st, blk_data_in);
  assign scr_data = scr_res[63:0];
  assign pif.clr  = (eff_blk == 5'h00);
  assign pif.vld  = blk_take;
  assign pif.dat  = scr_data;

  // Scrambler state follows the transmitted payload
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      scr_st <= 58'h0;
    end else if (blk_take) begin
      scr_st <= scr_res[121:64];
    end
  end

  jsf_parity u_parity (
    .sys_clk_in (sys_clk_in),
    .rst_in     (rst_in),
    .pif        (pif)
  );

  // ----------------------------------------------------------------
  // Sync header stream
  // ----------------------------------------------------------------
  logic [11:0] c;
  logic [25:0] f;
  logic [31:0] crc_word;
  logic [31:0] fec_word;
  logic [31:0] sh_word;
  logic        sh_bit;

  // Block zero reads the finished previous multiblock straight from the engine
  assign c = (eff_blk == 5'h00) ? pif.crc : crc_hold;
  assign f = (eff_blk == 5'h00) ? pif.fec : fec_hold;

  // CRC-12 layout, bit 31 down to bit 0
  assign crc_word = {1'b1, 4'h0, 3'h0, 1'b1, mb_last, 1'b1, 1'b0, 1'b1, 3'h0,
                     1'b1, c[0], c[1], c[2], 1'b1, c[3], c[4], c[5],
                     1'b1, c[6], c[7], c[8], 1'b1, c[9], c[10], c[11]};
  // FEC layout, bit 31 down to bit 0
  assign fec_word = fec_layout(f, mb_last);
  assign sh_word  = (mode == JSF_MODE_FEC) ? fec_word : crc_word;
  assign sh_bit   = sh_word[eff_blk];

  // Hold the previous multiblock parity for the rest of the stream
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      crc_hold <= 12'h000;
      fec_hold <= 26'h0000000;
    end else if (blk_take && eff_blk == 5'h00) begin
      crc_hold <= pif.crc;
      fec_hold <= pif.fec;
    end
  end

  // Transmit block: header in bits 0..1, payload above
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      blk_vld_out <= 1'b0;
      blk_out     <= 66'h0;
    end else begin
      blk_vld_out <= blk_take;
      if (blk_take) begin
        blk_out <= {scr_data, sh_bit, ~sh_bit};
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);

  hdr_differ_a: assert property (blk_vld_out |-> (blk_out[0] != blk_out[1]))
    else $error("sync header bits equal");
  blk_wrap_a: assert property ((blk_take && blk_end && !sr_edge) |=> blk_idx == 5'h00)
    else $error("block counter did not wrap after 32");
  blk_step_a: assert property ((blk_take && !blk_end && !sr_edge)
                               |=> blk_idx == $past(eff_blk) + 5'h01)
    else $error("block counter did not advance");
  pilot_tail_a: assert property ((blk_take && eff_blk >= 5'd27)
                                 |=> blk_out[1] == ($past(eff_blk) == 5'd31))
    else $error("end of multiblock pilot wrong");
  eoemb_flag_a: assert property ((blk_take && eff_blk == 5'd22)
                                 |=> blk_out[1] == $past(mb_last))
    else $error("extended multiblock flag wrong");
  crc_first_a: assert property ((blk_take && mode == JSF_MODE_CRC12 && eff_blk == 5'h00)
                                |=> blk_out[1] == $past(pif.crc[11]))
    else $error("CRC bit 11 not at stream position 0");
  fixed_ones_a: assert property ((blk_take && mode == JSF_MODE_CRC12 &&
                                  (eff_blk inside {5'h03, 5'h07, 5'h0B, 5'h0F,
                                                   5'h13, 5'h15, 5'h17}))
                                 |=> blk_out[1])
    else $error("fixed one missing in CRC stream");
  cmd_zero_a: assert property ((blk_take && mode == JSF_MODE_CRC12 &&
                                (eff_blk inside {5'd16, 5'd17, 5'd18, 5'd20,
                                                 5'd24, 5'd25, 5'd26}))
                               |=> !blk_out[1])
    else $error("command bit not zero");
  lemc_tick_a: assert property (lemc_out == $past(blk_take && blk_end && mb_last))
    else $error("LEMC pulse misplaced");
  mode_legal_a: assert property (mode == JSF_MODE_CRC12 || mode == JSF_MODE_FEC)
    else $error("unsupported sync header mode held");
  payload_a: assert property (blk_take |=> blk_out[65:2] == $past(scr_data))
    else $error("payload not carried above header");
endmodule : jsf_framer
`default_nettype wire

/* jsf_rx_model.sv */
// Receiver model: rebuilds the sync header stream and its own CRC-12
`timescale 1ns/10ps
`default_nettype none
module jsf_rx_model (
  input  wire logic        sys_clk_in,
  input  wire logic        rst_in,
  input  wire logic        restart_in,
  input  wire logic        blk_vld_in,
  input  wire logic [65:0] blk_in,
  output var  logic        mb_done_out,
  output var  logic [31:0] sh_word_out,
  output var  logic [11:0] crc_used_out,
  output var  logic        hdr_bad_out
);
  logic [4:0]  blk_idx;
  logic [31:0] sh_acc;
  logic [11:0] crc_acc;
  logic [11:0] crc_last;
  logic [11:0] next_crc;
  logic [31:0] next_sh;

  // Payload bits in line order through an MSB-first divider
  function automatic logic [11:0] crc_step(input logic [11:0] c, input logic [63:0] d);
    logic [11:0] r;
    logic        fb;
    r = c;
    for (int i = 0; i < 64; i++) begin
      fb = r[11] ^ d[i];
      r = {r[10:0], 1'h0} ^ (fb ? 12'h30F : 12'h000);
    end
    return r;
  endfunction : crc_step

  // Header bit 1 carries the stream bit of each block
  assign next_sh  = sh_acc | ({31'h0, blk_in[1]} << blk_idx);
  assign next_crc = crc_step(crc_acc, blk_in[65:2]);

  // Multiblock tracking; restart follows a realignment
  always_ff @(posedge sys_clk_in) begin
    mb_done_out <= 1'h0;
    hdr_bad_out <= 1'h0;
    if (rst_in || restart_in) begin
      blk_idx <= 5'h0;
      sh_acc  <= 32'h0;
      crc_acc <= 12'h0;
      if (rst_in) begin
        crc_last     <= 12'h0;
        sh_word_out  <= 32'h0;
        crc_used_out <= 12'h0;
      end
    end else if (blk_vld_in) begin
      hdr_bad_out <= (blk_in[0] == blk_in[1]);
      blk_idx     <= blk_idx + 5'h1;
      sh_acc      <= next_sh;
      crc_acc     <= next_crc;
      if (blk_idx == 5'h1F) begin
        mb_done_out  <= 1'h1;
        sh_word_out  <= next_sh;
        crc_used_out <= crc_last;
        crc_last     <= next_crc;
        sh_acc       <= 32'h0;
        crc_acc      <= 12'h0;
      end
    end
  end
endmodule : jsf_rx_model
`default_nettype wire

/* jsf_framer_tb_top.sv */
// Self-checking bench for the sync header framer
`timescale 1ns/10ps
`default_nettype none
module jsf_framer_tb_top;
  typedef struct {
    logic        fec;
    logic        eoemb;
    logic [31:0] mask;
  } jsf_note_s;

  logic              clk;
  logic              rst;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [7:0]        paddr;
  logic [31:0]       pwdata;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic              sysref;
  logic              blk_vld;
  logic [63:0]       blk_data;
  logic              vld_out;
  jsf_pkg::jsf_blk_t blk_q;
  logic              lemc;
  logic              restart;
  logic              mb_done;
  logic              hdr_bad;
  logic [31:0]       sh_word;
  logic [11:0]       crc_used;
  jsf_note_s         notes[$];
  jsf_note_s         cur;
  logic [31:0]       exp_w;
  int                num_errors;
  int                checked;
  int                n_out;
  int                n_lemc;
  int                seed;
  int                blk_k;
  int                mb_k;
  logic              enabled;
  logic              fec_mode;
  logic              skip_crc;
  logic [31:0]       rd;
  logic              err;

  jsf_framer i_jsf_framer (.sys_clk_in(clk), .rst_in(rst), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .sysref_in(sysref),
    .blk_vld_in(blk_vld), .blk_data_in(blk_data), .blk_vld_out(vld_out),
    .blk_out(blk_q), .lemc_out(lemc));

  jsf_rx_model i_jsf_rx_model (.sys_clk_in(clk), .rst_in(rst), .restart_in(restart),
    .blk_vld_in(vld_out), .blk_in(blk_q), .mb_done_out(mb_done), .sh_word_out(sh_word),
    .crc_used_out(crc_used), .hdr_bad_out(hdr_bad));

  // Clock at 200 MHz
  initial begin
    clk = 1'h0;
    forever #2.5 clk = ~clk;
  end

  // Stream word expected in CRC-12 mode
  function automatic logic [31:0] crc_word(input logic [11:0] c, input logic e);
    logic [31:0] w;
    w = 32'h80A8_8888;
    for (int i = 0; i < 12; i++) w[(i / 3) * 4 + i % 3] = c[11 - i];
    w[22] = e;
    return w;
  endfunction : crc_word

  // Places in a stream word where the end-of-multiblock pilot shows
  function automatic int pilot_hits(input logic [31:0] w);
    int n;
    n = 0;
    for (int k = 0; k < 28; k++) begin
      if (w[k +: 5] == 5'h10) n++;
    end
    return n;
  endfunction : pilot_hits

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h got %h", what, exp, got);
    end
  endtask : check

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] r, output logic e);
    int n;
    n = 0;
    psel    <= 1'h1;
    penable <= 1'h0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'h1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'h1);
    check("pready wait", 32'h1, 32'(n));
    r = prdata;
    e = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
    @(posedge clk);
  endtask : apb

  // Back-to-back blocks; a note per completed multiblock, E is two
  task automatic send_run(input int n);
    jsf_note_s nt;
    blk_vld <= 1'h1;
    for (int i = 0; i < n; i++) begin
      blk_data <= {$random(seed), $random(seed)};
      if (enabled) begin
        blk_k++;
        if (blk_k == 32) begin
          nt.fec   = fec_mode;
          nt.eoemb = (mb_k % 2 == 1);
          nt.mask  = fec_mode ? 32'hF840_0000 : (skip_crc ? 32'hFFFF_8888 : 32'hFFFF_FFFF);
          notes.push_back(nt);
          blk_k = 0;
          mb_k++;
          skip_crc = 1'h0;
        end
      end
      @(posedge clk);
    end
    blk_vld <= 1'h0;
    repeat (4) @(posedge clk);
  endtask : send_run

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : complete_run

  // Output monitor: counts pulses and compares each stream word
  always @(posedge clk) begin
    if (vld_out === 1'h1) n_out++;
    if (lemc === 1'h1) n_lemc++;
    if (hdr_bad === 1'h1) check("header pair", 32'h0, 32'h1);
    if (mb_done === 1'h1) begin
      if (notes.size() == 0) begin
        check("note queue", 32'h1, 32'h0);
      end else begin
        cur = notes.pop_front();
        exp_w = cur.fec ? {1'h1, 8'h0, cur.eoemb, 22'h0} : crc_word(crc_used, cur.eoemb);
        check("stream word", exp_w & cur.mask, sh_word & cur.mask);
        if (!cur.fec) check("pilot place", 32'h1, 32'(pilot_hits(sh_word)));
      end
    end
  end

  // Watchdog
  initial begin
    #100000;
    num_errors++;
    $display("ERROR watchdog expected finish got hang");
    complete_run();
  end

  // Main sequence
  initial begin
    {psel, penable, pwrite, sysref, blk_vld, restart} = 6'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    blk_data = 64'h0;
    {num_errors, checked, n_out, n_lemc, blk_k, mb_k} = '0;
    seed = 7;
    {enabled, fec_mode, skip_crc} = 3'h0;
    rst = 1'h1;
    repeat (12) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    apb(1'h0, 8'h00, 32'h0, rd, err);
    check("ctrl reset", 32'h0000_0100, rd);
    apb(1'h0, 8'h0C, 32'h0, rd, err);
    check("unmapped err", 32'h1, {31'h0, err});
    send_run(5);
    check("idle blocks", 32'h0, 32'(n_out));
    $display("test reset and idle done");
    enabled = 1'h1;
    apb(1'h1, 8'h00, 32'h0000_0201, rd, err);
    send_run(128);
    check("blocks out", 32'h80, 32'(n_out));
    check("lemc count", 32'h2, 32'(n_lemc));
    apb(1'h0, 8'h08, 32'h0, rd, err);
    check("parity reg", {20'h00000, crc_used}, rd);
    apb(1'h1, 8'h00, 32'h0000_0203, rd, err);
    apb(1'h0, 8'h00, 32'h0, rd, err);
    check("mode refused", 32'h0000_0201, rd);
    $display("test crc stream done");
    send_run(10);
    sysref <= 1'h1;
    repeat (3) @(posedge clk);
    sysref <= 1'h0;
    repeat (8) @(posedge clk);
    apb(1'h0, 8'h04, 32'h0, rd, err);
    check("realign flag", 32'h0001_0000, rd & 32'h0001_0000);
    restart <= 1'h1;
    @(posedge clk);
    restart <= 1'h0;
    {blk_k, mb_k} = '0;
    skip_crc = 1'h1;
    send_run(64);
    check("lemc realigned", 32'h3, 32'(n_lemc));
    $display("test realign done");
    fec_mode = 1'h1;
    apb(1'h1, 8'h00, 32'h0000_0205, rd, err);
    apb(1'h0, 8'h00, 32'h0, rd, err);
    check("fec mode", 32'h0000_0205, rd);
    send_run(64);
    check("notes left", 32'h0, 32'(notes.size()));
    $display("test fec stream done");
    complete_run();
  end
endmodule : jsf_framer_tb_top
`default_nettype wire
